//--- hw/mirq_pkg.sv
/*
 * shared constants of the metering interrupt, status and write-protect block:
 * register offsets, flag layout, special command codes, timing figures.
 * assumes a 100 MHz system clock and a 7-bit register address space.
 */
package mirq_pkg;

	////////////////////////////////////////////////////////////////////////
	// address space and register offsets
	localparam int          ADDR_W           = 7;
	localparam int          DATA_W           = 32;
	localparam logic [6:0]  OFS_IRQ_ENABLE   = 7'h40;
	localparam logic [6:0]  OFS_EVENT_FLAG   = 7'h41;
	localparam logic [6:0]  OFS_SHADOW_FLAG  = 7'h42;
	localparam logic [6:0]  OFS_SYS_STATE    = 7'h43;
	localparam logic [6:0]  OFS_READ_ECHO    = 7'h44;
	localparam logic [6:0]  OFS_WRITE_ECHO   = 7'h45;

	// protected windows: calibration and fast pulse counters
	localparam logic [6:0]  PROT_CAL_LO      = 7'h00;
	localparam logic [6:0]  PROT_CAL_HI      = 7'h10;
	localparam logic [6:0]  PROT_PULSE_LO    = 7'h20;
	localparam logic [6:0]  PROT_PULSE_HI    = 7'h21;

	////////////////////////////////////////////////////////////////////////
	// event and flag layout, shared by enable, flag and shadow views
	localparam int          EVT_W            = 6;
	localparam int          BIT_DATA_REFRESH = 0;
	localparam int          BIT_ACT_PULSE    = 1;
	localparam int          BIT_REACT_PULSE  = 2;
	localparam int          BIT_ACT_WRAP     = 3;
	localparam int          BIT_REACT_WRAP   = 4;
	localparam int          BIT_ZERO_CROSS   = 5;
	localparam logic [5:0]  IRQ_EN_RESET     = 6'h00;

	// system state bits
	localparam int          SYS_UNLOCK_BIT   = 4;
	localparam int          SYS_LINK_BIT     = 2;
	localparam int          SYS_RST_BIT      = 0;
	localparam logic        LINK_SPI         = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// special command frame
	localparam logic [7:0]  CMD_SPECIAL      = 8'hea;
	localparam logic [7:0]  CODE_UNLOCK      = 8'he5;
	localparam logic [7:0]  CODE_LOCK        = 8'hdc;
	localparam logic [7:0]  CODE_CHAN_A      = 8'h5a;
	localparam logic [7:0]  CODE_CHAN_B      = 8'ha5;

	////////////////////////////////////////////////////////////////////////
	// energy accumulators and result refresh timing
	localparam int          ENERGY_W         = 24;
	localparam logic [23:0] ENERGY_MAX       = 24'hff_ffff;
	localparam logic [23:0] ENERGY_ZERO      = 24'h00_0000;
	localparam int          CLK_HZ           = 100_000_000;
	localparam int          REFRESH_DECI_HZ  = 34;
	localparam int          DECI_PER_HZ      = 10;
	localparam int          REFRESH_CYC      =
		CLK_HZ / REFRESH_DECI_HZ * DECI_PER_HZ;

endpackage

//--- hw/mirq_sync_if.sv
/*
 * carrier between the top and its pin synchroniser: raw pin levels in,
 * filtered levels out.
 * assumes both ends share the system clock.
 */
interface mirq_sync_if #(
	parameter int W = 1
);
	logic [W-1:0] raw;
	logic [W-1:0] clean;

	modport owner (output raw, input clean);
	modport filt  (input raw, output clean);
endinterface

//--- hw/mirq_pin_sync.sv
/*
 * three-stage synchroniser for asynchronous pin levels; the filtered level
 * moves only when the second and third stages agree.
 * assumes pins change slowly against the system clock.
 */
module mirq_pin_sync #(
	parameter int W = 1
) (
	input  wire logic  clk,
	input  wire logic  rst_n,
	mirq_sync_if.filt  pins
);

	logic [W-1:0] stage1_ff;
	logic [W-1:0] stage2_ff;
	logic [W-1:0] stage3_ff;
	logic [W-1:0] clean_ff;

	////////////////////////////////////////////////////////////////////////
	// stage one feeds stage two only, metastability stays contained
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage1_ff <= '0;
			stage2_ff <= '0;
			stage3_ff <= '0;
		end
		else
		begin
			stage1_ff <= pins.raw;
			stage2_ff <= stage1_ff;
			stage3_ff <= stage2_ff;
		end
	end

	// per bit: accept a new level once two stages agree
	for (genvar i = 0; i < W; i++)
	begin : g_agree
		always_ff @(posedge clk or negedge rst_n)
		begin
			if (!rst_n)
				clean_ff[i] <= 1'b0;
			else if (stage2_ff[i] == stage3_ff[i])
				clean_ff[i] <= stage2_ff[i];
		end
	end

	assign pins.clean = clean_ff;

endmodule // mirq_pin_sync

//--- hw/mirq_top.sv
/*
 * interrupt, system status and write-protect logic of a single-phase
 * metering device: enable register, event flags with two clear-on-read
 * views, interrupt pin, status, read/write echo, special commands.
 * assumes the serial framing in front of it delivers one register access
 * or one special command per strobe, and that read and write strobes never
 * coincide. registers outside 0x40-0x45 live elsewhere; their read data
 * arrive on ext_rdata and their writes are gated by prot_wr_ok.
 */
// Contract
// [RL1] irq_n goes low whenever a flag is set with its enable bit set.
// [RL2] enable register is protected; locked writes to it are ignored.
// [RL3] enable bits: 5 zero-cross, 4/3 energy wraps, 2/1 pulses, 0 refresh.
// [RL4] data-refresh event raised at each result refresh, about 3.4 Hz.
// [RL5] any of six events sets its bit in the flag register, same layout.
// [RL6] flags set regardless of enables; enables gate only the pin.
// [RL7] primary flag register is read-only and cleared by reading it.
// [RL8] in SPI mode shadow view sets on events; reading clears both.
// [RL9] in single-wire mode shadow reads zero and its read clears nothing.
// [RL10] status bit4 is one while protected writes are permitted.
// [RL11] status bit2 mirrors the interface pin; one means SPI.
// [RL12] status bit0 set after reset ends, cleared when status is read.
// [RL13] read-echo register keeps the last data returned to the host.
// [RL14] write-echo register keeps the last data written by the host.
// [RL15] command 0xEA with 0xE5 unlocks writes, with 0xDC relocks.
// [RL16] protection covers 0x00-0x10, 0x20-0x21 and the enable register.
// [RL17] 0x5A selects channel A, 0xA5 channel B, only while unlocked.
// [RL18] channel-select status follows the executed channel command.
// [RL19] a 24-bit energy register wrapping all-ones to zero sets overflow.
// [RL20] special frames carry command byte 0xEA; next byte is the code.
// [RL21] irq_n returns high once no enabled flag remains set.
module mirq_top #(
	parameter int REFRESH_CYC = mirq_pkg::REFRESH_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        link_type_pin,
	input  wire logic [6:0]  reg_addr,
	input  wire logic        reg_rd,
	input  wire logic        reg_wr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic [31:0] ext_rdata,
	input  wire logic        cmd_valid,
	input  wire logic [7:0]  cmd_byte,
	input  wire logic [7:0]  cmd_data,
	input  wire logic        act_pulse_out,
	input  wire logic        reactive_pulse_out,
	input  wire logic        zero_cross_evt,
	input  wire logic [23:0] act_energy,
	input  wire logic [23:0] react_energy,
	output logic      [31:0] reg_rdata,
	output logic             reg_rvalid,
	output logic             prot_wr_ok,
	output logic             refresh_tick,
	output logic             active_current_channel,
	output logic             write_unlock_flag,
	output logic             irq_n
);

	localparam int CNT_W = $clog2(REFRESH_CYC + 1);
	localparam int EW    = mirq_pkg::EVT_W;

	////////////////////////////////////////////////////////////////////////
	// declarations

	logic [EW-1:0]  irq_enable_ff;
	logic [EW-1:0]  event_flag_ff;
	logic [EW-1:0]  shadow_flag_ff;
	logic [EW-1:0]  nxt_event_flag;
	logic [EW-1:0]  nxt_shadow_flag;
	logic [EW-1:0]  evt;
	logic           unlock_ff;
	logic           chan_b_ff;
	logic           rst_seen_ff;
	logic [31:0]    read_echo_ff;
	logic [31:0]    write_echo_ff;
	logic [31:0]    rdata_ff;
	logic [31:0]    nxt_rdata;
	logic           rvalid_ff;
	logic           irq_n_ff;
	logic [CNT_W-1:0] refresh_cnt_ff;
	logic           refresh_ff;
	logic [23:0]    act_prev_ff;
	logic [23:0]    react_prev_ff;
	logic           act_wrap;
	logic           react_wrap;
	logic           link_spi;
	logic           in_protected;
	logic           wr_allowed;
	logic           rd_flag;
	logic           rd_shadow;
	logic           rd_sys;
	logic           special_cmd;
	logic [7:0]     sys_state;

	////////////////////////////////////////////////////////////////////////
	// interface-select pin comes from outside the clock domain

	mirq_sync_if #(.W(1)) link_sync ();

	assign link_sync.raw = link_type_pin;

	mirq_pin_sync #(
		.W (1)
	) u_link_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.pins  (link_sync.filt)
	);

	assign link_spi = (link_sync.clean == mirq_pkg::LINK_SPI);

	////////////////////////////////////////////////////////////////////////
	// result refresh timer: drives the datapath and the refresh event

	// free running; the period is rounded down to whole cycles
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			refresh_cnt_ff <= '0;
			refresh_ff     <= 1'b0;
		end
		else if (refresh_cnt_ff == CNT_W'(REFRESH_CYC - 1))
		begin
			refresh_cnt_ff <= '0;
			refresh_ff     <= 1'b1; // RL4
		end
		else
		begin
			refresh_cnt_ff <= refresh_cnt_ff + CNT_W'(1);
			refresh_ff     <= 1'b0;
		end
	end

	assign refresh_tick = refresh_ff;

	////////////////////////////////////////////////////////////////////////
	// energy wrap detection on the accumulated registers

	// previous values, so a wrap is seen as all-ones followed by zero
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			act_prev_ff   <= mirq_pkg::ENERGY_ZERO;
			react_prev_ff <= mirq_pkg::ENERGY_ZERO;
		end
		else
		begin
			act_prev_ff   <= act_energy;
			react_prev_ff <= react_energy;
		end
	end

	// a host reload that jumps to zero from elsewhere is not a wrap
	assign act_wrap   = (act_prev_ff == mirq_pkg::ENERGY_MAX) &&
		(act_energy == mirq_pkg::ENERGY_ZERO); // RL19
	assign react_wrap = (react_prev_ff == mirq_pkg::ENERGY_MAX) &&
		(react_energy == mirq_pkg::ENERGY_ZERO); // RL19

	////////////////////////////////////////////////////////////////////////
	// event vector in enable/flag bit order

	always_comb
	begin
		evt = '0;
		evt[mirq_pkg::BIT_DATA_REFRESH] = refresh_ff; // RL4
		evt[mirq_pkg::BIT_ACT_PULSE]    = act_pulse_out;
		evt[mirq_pkg::BIT_REACT_PULSE]  = reactive_pulse_out;
		evt[mirq_pkg::BIT_ACT_WRAP]     = act_wrap;
		evt[mirq_pkg::BIT_REACT_WRAP]   = react_wrap;
		evt[mirq_pkg::BIT_ZERO_CROSS]   = zero_cross_evt; // RL3
	end

	////////////////////////////////////////////////////////////////////////
	// access decode and write protection

	// protected set: calibration window, pulse counters, enable register
	assign in_protected =
		((reg_addr >= mirq_pkg::PROT_CAL_LO) &&
		 (reg_addr <= mirq_pkg::PROT_CAL_HI)) ||
		((reg_addr >= mirq_pkg::PROT_PULSE_LO) &&
		 (reg_addr <= mirq_pkg::PROT_PULSE_HI)) ||
		(reg_addr == mirq_pkg::OFS_IRQ_ENABLE); // RL16

	assign wr_allowed = !in_protected || unlock_ff; // RL16

	// strobe for registers held outside; combinational handshake
	assign prot_wr_ok = reg_wr && wr_allowed &&
		(reg_addr != mirq_pkg::OFS_IRQ_ENABLE);

	assign rd_flag   = reg_rd && (reg_addr == mirq_pkg::OFS_EVENT_FLAG);
	assign rd_shadow = reg_rd && (reg_addr == mirq_pkg::OFS_SHADOW_FLAG);
	assign rd_sys    = reg_rd && (reg_addr == mirq_pkg::OFS_SYS_STATE);

	// only frames whose command byte is the special marker carry a code
	assign special_cmd = cmd_valid &&
		(cmd_byte == mirq_pkg::CMD_SPECIAL); // RL20

	////////////////////////////////////////////////////////////////////////
	// interrupt enable register

	// locked writes are dropped silently, no error is reported
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			irq_enable_ff <= mirq_pkg::IRQ_EN_RESET;
		else if (reg_wr && unlock_ff &&
			(reg_addr == mirq_pkg::OFS_IRQ_ENABLE))
			irq_enable_ff <= reg_wdata[EW-1:0]; // RL2 RL3
	end

	////////////////////////////////////////////////////////////////////////
	// event flags: primary and shadow views

	// a set in the clearing cycle wins so no event is lost
	always_comb
	begin
		nxt_event_flag  = event_flag_ff;
		nxt_shadow_flag = shadow_flag_ff;
		if (rd_flag)
			nxt_event_flag = '0; // RL7
		if (rd_shadow && link_spi)
		begin
			nxt_event_flag  = '0; // RL8
			nxt_shadow_flag = '0; // RL8
		end
		nxt_event_flag  = nxt_event_flag | evt; // RL5 RL6
		nxt_shadow_flag = nxt_shadow_flag | evt; // RL8
		if (!link_spi)
			nxt_shadow_flag = '0; // RL9
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			event_flag_ff  <= '0;
			shadow_flag_ff <= '0;
		end
		else
		begin
			event_flag_ff  <= nxt_event_flag;
			shadow_flag_ff <= nxt_shadow_flag;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt pin: low while any enabled flag stands

	// registered so the pin never glitches on decode paths
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			irq_n_ff <= 1'b1;
		else
			irq_n_ff <= !(|(nxt_event_flag & irq_enable_ff)); // RL1 RL21
	end

	assign irq_n = irq_n_ff;

	////////////////////////////////////////////////////////////////////////
	// special commands: unlock, relock, channel selection

	// unknown codes are ignored and leave the state alone
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			unlock_ff <= 1'b0;
		else if (special_cmd && (cmd_data == mirq_pkg::CODE_UNLOCK))
			unlock_ff <= 1'b1; // RL15
		else if (special_cmd && (cmd_data == mirq_pkg::CODE_LOCK))
			unlock_ff <= 1'b0; // RL15
	end

	// channel change refused while locked; channel A after reset
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			chan_b_ff <= 1'b0;
		else if (special_cmd && unlock_ff &&
			(cmd_data == mirq_pkg::CODE_CHAN_A))
			chan_b_ff <= 1'b0; // RL17 RL18
		else if (special_cmd && unlock_ff &&
			(cmd_data == mirq_pkg::CODE_CHAN_B))
			chan_b_ff <= 1'b1; // RL17 RL18
	end

	assign active_current_channel = chan_b_ff;
	assign write_unlock_flag      = unlock_ff;

	////////////////////////////////////////////////////////////////////////
	// system state

	// reset-seen is set while reset is held, reading the status clears it
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rst_seen_ff <= 1'b1; // RL12
		else if (rd_sys)
			rst_seen_ff <= 1'b0; // RL12
	end

	always_comb
	begin
		sys_state = '0;
		sys_state[mirq_pkg::SYS_UNLOCK_BIT] = unlock_ff; // RL10
		sys_state[mirq_pkg::SYS_LINK_BIT]   = link_spi; // RL11
		sys_state[mirq_pkg::SYS_RST_BIT]    = rst_seen_ff; // RL12
	end

	////////////////////////////////////////////////////////////////////////
	// read data selection

	// registers of the block answer here, everything else passes through
	always_comb
	begin
		nxt_rdata = '0;
		unique case (reg_addr)
			mirq_pkg::OFS_IRQ_ENABLE:
				nxt_rdata = 32'(irq_enable_ff);
			mirq_pkg::OFS_EVENT_FLAG:
				nxt_rdata = 32'(event_flag_ff);
			mirq_pkg::OFS_SHADOW_FLAG:
				nxt_rdata = link_spi ? 32'(shadow_flag_ff) : '0; // RL9
			mirq_pkg::OFS_SYS_STATE:
				nxt_rdata = 32'(sys_state);
			mirq_pkg::OFS_READ_ECHO:
				nxt_rdata = read_echo_ff;
			mirq_pkg::OFS_WRITE_ECHO:
				nxt_rdata = write_echo_ff;
			default:
				nxt_rdata = ext_rdata;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata_ff  <= '0;
			rvalid_ff <= 1'b0;
		end
		else
		begin
			rvalid_ff <= reg_rd;
			if (reg_rd)
				rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata  = rdata_ff;
	assign reg_rvalid = rvalid_ff;

	////////////////////////////////////////////////////////////////////////
	// transfer echo registers for host-side checking

	// the echo shows the value as returned, so reading it echoes itself
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			read_echo_ff <= '0;
		else if (reg_rd)
			read_echo_ff <= nxt_rdata; // RL13
	end

	// every write is echoed, even one refused by protection
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			write_echo_ff <= '0;
		else if (reg_wr)
			write_echo_ff <= reg_wdata; // RL14
	end

endmodule // mirq_top

//--- verif/mirq_host_model.sv
/*
 * host model: register and special-command strobes, and the data of
 * registers outside the block.
 * assumes the block answers a read exactly one cycle after its strobe.
 */
module mirq_host_model (
	input  wire logic        clk,
	input  wire logic [31:0] reg_rdata,
	input  wire logic        reg_rvalid,
	output logic      [6:0]  reg_addr,
	output logic             reg_rd,
	output logic             reg_wr,
	output logic      [31:0] reg_wdata,
	output logic      [31:0] ext_rdata,
	output logic             cmd_valid,
	output logic      [7:0]  cmd_byte,
	output logic      [7:0]  cmd_data
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [31:0] EXT_WORD = 32'h5a5a_0f0f;

	// idle strobes; outside data shows its inverse when nobody reads
	initial
	begin
		reg_addr  = 7'h00;
		reg_rd    = 1'b0;
		reg_wr    = 1'b0;
		reg_wdata = 32'h0000_0000;
		ext_rdata = ~EXT_WORD;
		cmd_valid = 1'b0;
		cmd_byte  = 8'h00;
		cmd_data  = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// read: one strobe cycle, answer taken at the edge where it stands
	task automatic rd(input logic [6:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_rd    <= 1'b1;
		ext_rdata <= EXT_WORD;
		@(posedge clk);
		reg_rd    <= 1'b0;
		ext_rdata <= ~EXT_WORD;
		@(posedge clk);
		d = (reg_rvalid === 1'b1) ? reg_rdata : 32'hxxxx_xxxx;
	endtask

	// write: data scrambled after release so stale values never match
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
		reg_wdata <= ~d;
	endtask

	// special frame: command byte then code byte, one strobe
	task automatic cmd(input logic [7:0] b, input logic [7:0] c);
		@(posedge clk);
		cmd_byte  <= b;
		cmd_data  <= c;
		cmd_valid <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_byte  <= ~b;
		cmd_data  <= ~c;
	endtask
endmodule // mirq_host_model

//--- verif/mirq_top_props.sv
/*
 * concurrent checks on the ports of the interrupt and protect block.
 * assumes one clock and the asynchronous active-low reset.
 */
module mirq_top_props #(
	parameter int REFRESH_CYC = 50
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [6:0]  reg_addr,
	input  wire logic        reg_rd,
	input  wire logic        reg_wr,
	input  wire logic        cmd_valid,
	input  wire logic [7:0]  cmd_byte,
	input  wire logic [7:0]  cmd_data,
	input  wire logic        act_pulse_out,
	input  wire logic        reactive_pulse_out,
	input  wire logic        zero_cross_evt,
	input  wire logic [23:0] act_energy,
	input  wire logic [23:0] react_energy,
	input  wire logic        reg_rvalid,
	input  wire logic        prot_wr_ok,
	input  wire logic        refresh_tick,
	input  wire logic        active_current_channel,
	input  wire logic        write_unlock_flag,
	input  wire logic        irq_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [31:0] tick_cnt_ff;
	logic        tick_seen_ff;
	logic        evt_ff;
	logic [23:0] act_prev_ff;
	logic [23:0] react_prev_ff;
	wire         cmd_ok = cmd_valid && cmd_byte == mirq_pkg::CMD_SPECIAL;
	wire         wrap = (act_prev_ff == 24'hff_ffff && act_energy == 24'h0)
		|| (react_prev_ff == 24'hff_ffff && react_energy == 24'h0);

	// cycles since the last refresh tick; the first tick is not timed
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			tick_cnt_ff  <= 32'h0000_0000;
			tick_seen_ff <= 1'b0;
		end
		else
		begin
			tick_cnt_ff  <= refresh_tick ? 32'h0000_0001 : tick_cnt_ff + 1;
			tick_seen_ff <= tick_seen_ff | refresh_tick;
		end

	// any event of the previous cycle, wraps included
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			evt_ff        <= 1'b0;
			act_prev_ff   <= 24'h00_0000;
			react_prev_ff <= 24'h00_0000;
		end
		else
		begin
			evt_ff        <= act_pulse_out | reactive_pulse_out | wrap
				| zero_cross_evt | refresh_tick;
			act_prev_ff   <= act_energy;
			react_prev_ff <= react_energy;
		end

	////////////////////////////////////////////////////////////////////////
	read_answer_a: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered next cycle");
	answer_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("read answer without request");
	unlock_cmd_a: assert property (cmd_ok && cmd_data == 8'he5
		|=> write_unlock_flag) else $error("unlock not taken");
	lock_cmd_a: assert property (cmd_ok && cmd_data == 8'hdc
		|=> !write_unlock_flag) else $error("lock not taken");
	unlock_hold_a: assert property (!cmd_ok
		|=> $stable(write_unlock_flag)) else $error("unlock moved");
	chan_locked_a: assert property (!write_unlock_flag
		|=> $stable(active_current_channel)) else $error("channel moved");
	chan_b_a: assert property (cmd_ok && cmd_data == 8'ha5
		&& write_unlock_flag |=> active_current_channel)
		else $error("channel b not selected");
	enable_prot_a: assert property (reg_wr && reg_addr == 7'h40
		|-> !prot_wr_ok) else $error("enable write passed outward");
	cal_prot_a: assert property (reg_wr && reg_addr <= 7'h10
		&& !write_unlock_flag |-> !prot_wr_ok)
		else $error("locked calibration write passed");
	refresh_period_a: assert property (refresh_tick && tick_seen_ff
		|-> tick_cnt_ff == REFRESH_CYC) else $error("refresh period off");
	irq_fall_a: assert property ($fell(irq_n) |-> evt_ff
		|| $past(reg_wr) || $past(reg_wr, 2))
		else $error("interrupt without event");
	irq_rise_a: assert property ($rose(irq_n) |-> $past(reg_rd)
		|| $past(reg_rd, 2) || $past(reg_wr) || $past(reg_wr, 2))
		else $error("interrupt released without cause");

	cover property (reg_rd && reg_addr == 7'h42);
	cover property ($fell(irq_n));
	cover property (cmd_ok && cmd_data == 8'ha5 && write_unlock_flag);
endmodule // mirq_top_props

bind mirq_top mirq_top_props #(.REFRESH_CYC(REFRESH_CYC)) u_mirq_top_props (
	.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
	.reg_wr(reg_wr), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
	.cmd_data(cmd_data), .act_pulse_out(act_pulse_out),
	.reactive_pulse_out(reactive_pulse_out), .act_energy(act_energy),
	.zero_cross_evt(zero_cross_evt), .react_energy(react_energy),
	.reg_rvalid(reg_rvalid), .irq_n(irq_n),
	.prot_wr_ok(prot_wr_ok), .refresh_tick(refresh_tick),
	.active_current_channel(active_current_channel),
	.write_unlock_flag(write_unlock_flag));

//--- verif/mirq_top_tb.sv
/*
 * self-checking bench of the interrupt, status and write-protect block.
 * assumes the host model and a short refresh period.
 */
module mirq_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int RCYC = 200;
	logic        clk, rst_n, link_type_pin, reg_rd, reg_wr, cmd_valid;
	logic        act_pulse_out, reactive_pulse_out, zero_cross_evt;
	logic        reg_rvalid, prot_wr_ok, refresh_tick, irq_n;
	logic        active_current_channel, write_unlock_flag;
	logic [6:0]  reg_addr;
	logic [7:0]  cmd_byte, cmd_data;
	logic [23:0] act_energy, react_energy;
	logic [31:0] reg_wdata, ext_rdata, reg_rdata, d;
	int          fail_count, n_compared, cyc_cnt;

	mirq_top #(.REFRESH_CYC(RCYC)) u_mirq_top (.clk(clk), .rst_n(rst_n),
		.link_type_pin(link_type_pin), .reg_addr(reg_addr), .reg_rd(reg_rd),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .ext_rdata(ext_rdata),
		.cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_data(cmd_data),
		.act_pulse_out(act_pulse_out), .zero_cross_evt(zero_cross_evt),
		.reactive_pulse_out(reactive_pulse_out), .act_energy(act_energy),
		.react_energy(react_energy), .reg_rdata(reg_rdata), .irq_n(irq_n),
		.reg_rvalid(reg_rvalid), .prot_wr_ok(prot_wr_ok),
		.refresh_tick(refresh_tick), .write_unlock_flag(write_unlock_flag),
		.active_current_channel(active_current_channel));
	mirq_host_model u_mirq_host_model (.clk(clk), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .reg_addr(reg_addr), .reg_rd(reg_rd),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .ext_rdata(ext_rdata),
		.cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_data(cmd_data));

	always #5 clk = ~clk;

	// hang guard, far above the expected run
	always @(posedge clk)
	begin
		cyc_cnt++;
		if (cyc_cnt == 20000)
		begin
			fail_count++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error at %0t: got %h, want %h", $time, seen, exp);
		end
	endtask

	// returns at the edge where a refresh tick stands
	task automatic sync();
		for (int i = 0; i < RCYC + 20; i++)
		begin
			@(posedge clk);
			if (refresh_tick === 1'b1)
				break;
		end
	endtask

	// one event of kind k; wraps need an extra edge to be seen
	task automatic fire(input int k);
		@(posedge clk);
		case (k)
			1: act_pulse_out <= 1'b1;
			2: reactive_pulse_out <= 1'b1;
			3: act_energy <= 24'hff_ffff;
			4: react_energy <= 24'hff_ffff;
			default: zero_cross_evt <= 1'b1;
		endcase
		@(posedge clk);
		act_pulse_out      <= 1'b0;
		reactive_pulse_out <= 1'b0;
		zero_cross_evt     <= 1'b0;
		act_energy         <= 24'h00_0000;
		react_energy       <= 24'h00_0000;
		@(posedge clk);
		if (k == 3 || k == 4)
			@(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// short forms of the host strobes; read data land in d
	task automatic rd(input logic [6:0] a);
		u_mirq_host_model.rd(a, d);
	endtask

	task automatic cmd(input logic [7:0] b, input logic [7:0] c);
		u_mirq_host_model.cmd(b, c);
	endtask

	task automatic t_status();
		rd(7'h43);
		chk(d, 32'h0000_0005);
		rd(7'h43);
		chk(d, 32'h0000_0004);
		rd(7'h40);
		chk(d, 32'h0000_0000);
	endtask

	// locked writes dropped but echoed; unlocked writes land
	task automatic t_protect();
		u_mirq_host_model.wr(7'h40, 32'hffff_ffff);
		u_mirq_host_model.wr(7'h05, 32'h0000_1234);
		rd(7'h40);
		chk(d, 32'h0000_0000);
		rd(7'h45);
		chk(d, 32'h0000_1234);
		rd(7'h44);
		chk(d, 32'h0000_1234);
		rd(7'h05);
		rd(7'h44);
		chk(d, 32'h5a5a_0f0f);
		cmd(8'hea, 8'he5);
		rd(7'h43);
		chk(d, 32'h0000_0014);
		u_mirq_host_model.wr(7'h40, 32'hffff_ffff);
		u_mirq_host_model.wr(7'h20, 32'h0000_0000);
		cmd(8'hea, 8'hdc);
		u_mirq_host_model.wr(7'h40, 32'h0000_0000);
		rd(7'h40);
		chk(d, 32'h0000_003f);
		rd(7'h43);
		chk(d, 32'h0000_0004);
	endtask

	task automatic t_chan();
		cmd(8'hea, 8'ha5);
		@(posedge clk);
		chk(active_current_channel, 1'b0);
		cmd(8'h15, 8'he5);
		@(posedge clk);
		chk(write_unlock_flag, 1'b0);
		cmd(8'hea, 8'he5);
		cmd(8'hea, 8'ha5);
		@(posedge clk);
		chk(active_current_channel, 1'b1);
		cmd(8'hea, 8'h5a);
		@(posedge clk);
		chk(active_current_channel, 1'b0);
		cmd(8'hea, 8'hdc);
	endtask

	// every pulse, wrap and zero-cross event: flag, pin, both clear-on-read views
	task automatic t_events();
		int n;
		sync();
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (refresh_tick !== 1'b1 && n < RCYC + 20);
		chk(n, RCYC);
		for (int k = 1; k < 6; k++)
		begin
			sync();
			rd(7'h42);
			chk(d, 32'h0000_0001);
			rd(7'h41);
			chk(d, 32'h0000_0000);
			fire(k);
			chk(irq_n, 1'b0);
			rd(7'h41);
			chk(d, 32'h1 << k);
			chk(irq_n, 1'b1);
			rd(7'h42);
			chk(d, 32'h1 << k);
		end
		cmd(8'hea, 8'he5);
		u_mirq_host_model.wr(7'h40, 32'h0000_0000);
		cmd(8'hea, 8'hdc);
		fire(1);
		chk(irq_n, 1'b1);
		rd(7'h41);
		chk(d & 32'h0000_0002, 32'h0000_0002);
	endtask

	// single-wire link: shadow view dead, primary untouched by it
	task automatic t_single();
		@(posedge clk);
		link_type_pin <= 1'b0;
		repeat (5) @(posedge clk);
		rd(7'h43);
		chk(d, 32'h0000_0000);
		sync();
		rd(7'h41);
		fire(5);
		rd(7'h42);
		chk(d, 32'h0000_0000);
		rd(7'h41);
		chk(d, 32'h0000_0020);
	endtask

	initial
	begin
		clk                = 1'b0;
		rst_n              = 1'b0;
		link_type_pin      = 1'b1;
		act_pulse_out      = 1'b0;
		reactive_pulse_out = 1'b0;
		zero_cross_evt     = 1'b0;
		act_energy         = 24'h00_0000;
		react_energy       = 24'h00_0000;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_status();
		t_protect();
		t_chan();
		t_events();
		t_single();
		stop_test();
	end
endmodule // mirq_top_tb
